// ==== tcp_pkg.sv ====
// Constants for the tensor command parameter decoder
//  Operation
// - Command word: bits 15:10 zero, bits 9:0 select, no extra data.
// - The 16-bit parameter starts an action or sets held state.
// - Kernel wait holds the next command until unfinished kernels <= n (0-3).
// - Convolution, depthwise, pooling and elementwise starts count as kernel operations.
// - Top/left padding 0-127, right/bottom padding 0-128.
// - With upscaling selected, padding applies to the upscaled input.
// - Input depth command stores channel count minus one, 0-65535.
// - Input precision: bit 0 signedness, bits 3:2 give 8/16/32-bit.
// - Input precision bits 7:6 pick channel-last or brick16 layout.
// - Input precision bits 9:8 pick elementwise add/sub scale mode.
// - Input precision bits 15:14 pick double or nearest-up rounding.
// - Upscale bits 1:0: none, 2x2 nearest, 2x2 zero insertion.
// - Input zero offset is signed or unsigned 16-bit by activation type.
// - Tile width, tile0 height, tile1 height stored minus one, input and output.
// - Input buffer end in KB, 0 to 48, multiples of 2.
// - Region commands pick index 0-7 added to input or output addresses.
// - Output stripe width, height, depth held minus one, 0-65535.
// - Output precision: bit 0 sign, bits 2:1 precision, bits 7:6 layout.
// - Output precision bit 8 scale mode, bits 15:14 rounding mode.
// - Block width/height minus one 0-31, block depth minus one 3-127.
// - Output zero offset signed/unsigned 16-bit, legal for the clip range.
// - Kernel width/height commands carry dilated size minus one.
package tcp_pkg;
  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [9:0] CMD_CONV         = 10'h002;
  localparam logic [9:0] CMD_DEPTHWISE    = 10'h003;
  localparam logic [9:0] CMD_POOL         = 10'h005;
  localparam logic [9:0] CMD_ELEMENTWISE  = 10'h006;
  localparam logic [9:0] CMD_KERNEL_WAIT  = 10'h012;
  localparam logic [9:0] CMD_PAD_TOP      = 10'h100;
  localparam logic [9:0] CMD_PAD_LEFT     = 10'h101;
  localparam logic [9:0] CMD_PAD_RIGHT    = 10'h102;
  localparam logic [9:0] CMD_PAD_BOTTOM   = 10'h103;
  localparam logic [9:0] CMD_IN_DEPTH     = 10'h104;
  localparam logic [9:0] CMD_IN_PREC      = 10'h105;
  localparam logic [9:0] CMD_IN_UPSCALE   = 10'h107;
  localparam logic [9:0] CMD_IN_ZERO      = 10'h109;
  localparam logic [9:0] CMD_IN_TILE_W    = 10'h10A;
  localparam logic [9:0] CMD_IN_TILE0_H   = 10'h10B;
  localparam logic [9:0] CMD_IN_TILE1_H   = 10'h10C;
  localparam logic [9:0] CMD_IN_BUF_END   = 10'h10D;
  localparam logic [9:0] CMD_IN_REGION    = 10'h10F;
  localparam logic [9:0] CMD_OUT_W        = 10'h111;
  localparam logic [9:0] CMD_OUT_H        = 10'h112;
  localparam logic [9:0] CMD_OUT_D        = 10'h113;
  localparam logic [9:0] CMD_OUT_PREC     = 10'h114;
  localparam logic [9:0] CMD_BLK_W        = 10'h115;
  localparam logic [9:0] CMD_BLK_H        = 10'h116;
  localparam logic [9:0] CMD_BLK_D        = 10'h117;
  localparam logic [9:0] CMD_OUT_ZERO     = 10'h118;
  localparam logic [9:0] CMD_OUT_TILE_W   = 10'h11A;
  localparam logic [9:0] CMD_OUT_TILE0_H  = 10'h11B;
  localparam logic [9:0] CMD_OUT_TILE1_H  = 10'h11C;
  localparam logic [9:0] CMD_OUT_REGION   = 10'h11F;
  localparam logic [9:0] CMD_KERNEL_W     = 10'h120;
  localparam logic [9:0] CMD_KERNEL_H     = 10'h121;
  localparam logic [9:0] CMD_RANGE_LO     = 10'h100;
  localparam logic [9:0] CMD_RANGE_HI     = 10'h121;

  // ****************************************************************
  // Command word and parameter fields
  // ****************************************************************
  localparam int CMD_SEL_MSB      = 9;
  localparam int CMD_ZERO_LSB     = 10;
  localparam int WAIT_N_MSB       = 1;
  localparam int IP_SIGN_POS      = 0;
  localparam int IP_PREC_LSB      = 2;
  localparam int IP_LAYOUT_LSB    = 6;
  localparam int IP_EWSCALE_LSB   = 8;
  localparam int IP_ROUND_LSB     = 14;
  localparam int OP_SIGN_POS      = 0;
  localparam int OP_PREC_LSB      = 1;
  localparam int OP_LAYOUT_LSB    = 6;
  localparam int OP_SCALE_POS     = 8;
  localparam int OP_ROUND_LSB     = 14;

  // ****************************************************************
  // Parameter limits
  // ****************************************************************
  localparam logic [15:0] PAD_TL_MAX     = 16'h007F;
  localparam logic [15:0] PAD_RB_MAX     = 16'h0080;
  localparam logic [15:0] BUF_END_MAX    = 16'h0030;
  localparam logic [15:0] REGION_MAX     = 16'h0007;
  localparam logic [15:0] BLK_WH_MAX     = 16'h001F;
  localparam logic [15:0] BLK_D_MIN      = 16'h0003;
  localparam logic [15:0] BLK_D_MAX      = 16'h007F;
  localparam logic [15:0] WAIT_N_MAX     = 16'h0003;
  localparam logic [3:0]  KCOUNT_MAX     = 4'hF;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [6:0]  BLK_D_RST      = 7'h03;
  localparam logic        CTRL_EN_RST    = 1'b1;

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_STATUS     = 12'h004;
  localparam logic [11:0] REG_ERR        = 12'h008;
  localparam logic [11:0] REG_LAST_CMD   = 12'h00C;
  localparam int          ERR_UNK_POS    = 0;
  localparam int          ERR_RANGE_POS  = 1;
  localparam int          ST_WAIT_POS    = 4;
  localparam int          ST_PADUP_POS   = 5;
endpackage : tcp_pkg

// ==== tcp_decoder.sv ====
// Command parameter decoder: command stream intake, kernel wait and parameter state
`timescale 1ns/1ps
`default_nettype none
module tcp_decoder (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Command stream
  input  wire logic        i_cmd_valid,
  input  wire logic [15:0] i_cmd_word,
  input  wire logic [15:0] i_cmd_param,
  output logic             o_cmd_ready,
  // Kernel completion from the datapath
  input  wire logic        i_kernel_done,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Input feature map state
  output logic [6:0]       o_pad_top,
  output logic [6:0]       o_pad_left,
  output logic [7:0]       o_pad_right,
  output logic [7:0]       o_pad_bottom,
  output logic             o_pad_after_upscale,
  output logic [15:0]      o_in_depth_m1,
  output logic             o_in_signed,
  output logic [1:0]       o_in_prec,
  output logic [1:0]       o_in_layout,
  output logic [1:0]       o_in_ew_scale,
  output logic [1:0]       o_in_round,
  output logic [1:0]       o_in_upscale,
  output logic [16:0]      o_in_zero_ext,
  output logic [15:0]      o_in_tile_w_m1,
  output logic [15:0]      o_in_tile0_h_m1,
  output logic [15:0]      o_in_tile1_h_m1,
  output logic [5:0]       o_in_buf_end,
  output logic [2:0]       o_in_region,
  // Output feature map state
  output logic [15:0]      o_out_w_m1,
  output logic [15:0]      o_out_h_m1,
  output logic [15:0]      o_out_d_m1,
  output logic             o_out_signed,
  output logic [1:0]       o_out_prec,
  output logic [1:0]       o_out_layout,
  output logic             o_out_global_scale,
  output logic [1:0]       o_out_round,
  output logic [4:0]       o_blk_w_m1,
  output logic [4:0]       o_blk_h_m1,
  output logic [6:0]       o_blk_d_m1,
  output logic [16:0]      o_out_zero_ext,
  output logic [15:0]      o_out_tile_w_m1,
  output logic [15:0]      o_out_tile0_h_m1,
  output logic [15:0]      o_out_tile1_h_m1,
  output logic [2:0]       o_out_region,
  output logic [15:0]      o_kernel_w_m1,
  output logic [15:0]      o_kernel_h_m1,
  // Kernel operation start strobe
  output logic             o_kernel_start
);

  // ****************************************************************
  // Intake
  // ****************************************************************
  typedef enum logic {ST_RUN, ST_WAIT} tcp_state_e;

  tcp_state_e  state_reg;
  tcp_state_e  state_next;
  logic        take;
  logic        is_cmd0;
  logic [9:0]  code;
  logic [15:0] p;
  logic [1:0]  wait_n_reg;
  logic [3:0]  kcount_reg;
  logic [3:0]  kcount_next;
  logic        kstart;
  logic        known;
  logic        in_range;
  logic        bad_value;
  logic        ctrl_en_reg;
  logic [1:0]  err_reg;
  logic [9:0]  last_cmd_reg;
  logic [15:0] in_zero_reg;
  logic [15:0] out_zero_reg;
  logic        apb_wr;
  logic [31:0] rd_mux;
  logic        rd_ok;

  assign take    = i_cmd_valid && o_cmd_ready;
  assign is_cmd0 = (i_cmd_word[15:tcp_pkg::CMD_ZERO_LSB] == 6'h00);
  assign code    = i_cmd_word[tcp_pkg::CMD_SEL_MSB:0];
  assign p       = i_cmd_param;

  // Kernel operations counted from their own start commands
  assign kstart = take && is_cmd0 && (code == tcp_pkg::CMD_CONV ||
                  code == tcp_pkg::CMD_DEPTHWISE || code == tcp_pkg::CMD_POOL ||
                  code == tcp_pkg::CMD_ELEMENTWISE);

  // Saturating count keeps a stray done pulse from wrapping
  always_comb begin
    kcount_next = kcount_reg;
    if (kstart && !i_kernel_done && kcount_reg != tcp_pkg::KCOUNT_MAX) begin
      kcount_next = kcount_reg + 4'h1;
    end else if (!kstart && i_kernel_done && kcount_reg != 4'h0) begin
      kcount_next = kcount_reg - 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      kcount_reg <= 4'h0;
    end else begin
      kcount_reg <= kcount_next;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_kernel_start <= 1'b0;
    end else begin
      o_kernel_start <= kstart;
    end
  end

  // ****************************************************************
  // Kernel wait sequencing
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (take && is_cmd0 && code == tcp_pkg::CMD_KERNEL_WAIT) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (kcount_next <= {2'b00, wait_n_reg}) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg  <= ST_RUN;
      wait_n_reg <= 2'b00;
    end else begin
      state_reg <= state_next;
      if (take && is_cmd0 && code == tcp_pkg::CMD_KERNEL_WAIT) begin
        wait_n_reg <= p[tcp_pkg::WAIT_N_MSB:0];
      end
    end
  end

  // Ready is held low while waiting, so the next command stays on the stream
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_ready <= 1'b0;
    end else begin
      o_cmd_ready <= (state_next == ST_RUN) && ctrl_en_reg;
    end
  end

  // ****************************************************************
  // Code classification
  // ****************************************************************
  always_comb begin
    known = 1'b1;
    bad_value = 1'b0;
    unique case (code)
      tcp_pkg::CMD_PAD_TOP, tcp_pkg::CMD_PAD_LEFT:
        bad_value = (p > tcp_pkg::PAD_TL_MAX);
      tcp_pkg::CMD_PAD_RIGHT, tcp_pkg::CMD_PAD_BOTTOM:
        bad_value = (p > tcp_pkg::PAD_RB_MAX);
      tcp_pkg::CMD_IN_BUF_END:
        bad_value = (p > tcp_pkg::BUF_END_MAX) || p[0];
      tcp_pkg::CMD_IN_REGION, tcp_pkg::CMD_OUT_REGION:
        bad_value = (p > tcp_pkg::REGION_MAX);
      tcp_pkg::CMD_BLK_W, tcp_pkg::CMD_BLK_H:
        bad_value = (p > tcp_pkg::BLK_WH_MAX);
      tcp_pkg::CMD_BLK_D:
        bad_value = (p < tcp_pkg::BLK_D_MIN) || (p > tcp_pkg::BLK_D_MAX);
      tcp_pkg::CMD_IN_DEPTH, tcp_pkg::CMD_IN_PREC, tcp_pkg::CMD_IN_UPSCALE,
      tcp_pkg::CMD_IN_ZERO, tcp_pkg::CMD_IN_TILE_W, tcp_pkg::CMD_IN_TILE0_H,
      tcp_pkg::CMD_IN_TILE1_H, tcp_pkg::CMD_OUT_W, tcp_pkg::CMD_OUT_H,
      tcp_pkg::CMD_OUT_D, tcp_pkg::CMD_OUT_PREC, tcp_pkg::CMD_OUT_ZERO,
      tcp_pkg::CMD_OUT_TILE_W, tcp_pkg::CMD_OUT_TILE0_H, tcp_pkg::CMD_OUT_TILE1_H,
      tcp_pkg::CMD_KERNEL_W, tcp_pkg::CMD_KERNEL_H:
        bad_value = 1'b0;
      default:
        known = 1'b0;
    endcase
  end

  assign in_range = (code >= tcp_pkg::CMD_RANGE_LO) && (code <= tcp_pkg::CMD_RANGE_HI);

  // ****************************************************************
  // Parameter state, held until rewritten
  // ****************************************************************
  // Out-of-range values are flagged but still latched in the low bits
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pad_top     <= 7'h00;
      o_pad_left    <= 7'h00;
      o_pad_right   <= 8'h00;
      o_pad_bottom  <= 8'h00;
      o_in_depth_m1 <= 16'h0000;
      o_in_signed   <= 1'b0;
      o_in_prec     <= 2'h0;
      o_in_layout   <= 2'h0;
      o_in_ew_scale <= 2'h0;
      o_in_round    <= 2'h0;
      o_in_upscale  <= 2'h0;
      in_zero_reg   <= 16'h0000;
      o_in_buf_end  <= 6'h00;
      o_in_region   <= 3'h0;
    end else if (take && is_cmd0 && known) begin
      unique case (code)
        tcp_pkg::CMD_PAD_TOP:    o_pad_top <= p[6:0];
        tcp_pkg::CMD_PAD_LEFT:   o_pad_left <= p[6:0];
        tcp_pkg::CMD_PAD_RIGHT:  o_pad_right <= p[7:0];
        tcp_pkg::CMD_PAD_BOTTOM: o_pad_bottom <= p[7:0];
        tcp_pkg::CMD_IN_DEPTH:   o_in_depth_m1 <= p;
        tcp_pkg::CMD_IN_PREC: begin
          o_in_signed   <= p[tcp_pkg::IP_SIGN_POS];
          o_in_prec     <= p[tcp_pkg::IP_PREC_LSB +: 2];
          o_in_layout   <= p[tcp_pkg::IP_LAYOUT_LSB +: 2];
          o_in_ew_scale <= p[tcp_pkg::IP_EWSCALE_LSB +: 2];
          o_in_round    <= p[tcp_pkg::IP_ROUND_LSB +: 2];
        end
        tcp_pkg::CMD_IN_UPSCALE: o_in_upscale <= p[1:0];
        tcp_pkg::CMD_IN_ZERO:    in_zero_reg <= p;
        tcp_pkg::CMD_IN_BUF_END: o_in_buf_end <= p[5:0];
        tcp_pkg::CMD_IN_REGION:  o_in_region <= p[2:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_in_tile_w_m1   <= 16'h0000;
      o_in_tile0_h_m1  <= 16'h0000;
      o_in_tile1_h_m1  <= 16'h0000;
      o_out_tile_w_m1  <= 16'h0000;
      o_out_tile0_h_m1 <= 16'h0000;
      o_out_tile1_h_m1 <= 16'h0000;
      o_out_w_m1       <= 16'h0000;
      o_out_h_m1       <= 16'h0000;
      o_out_d_m1       <= 16'h0000;
      o_kernel_w_m1    <= 16'h0000;
      o_kernel_h_m1    <= 16'h0000;
    end else if (take && is_cmd0 && known) begin
      unique case (code)
        tcp_pkg::CMD_IN_TILE_W:   o_in_tile_w_m1 <= p;
        tcp_pkg::CMD_IN_TILE0_H:  o_in_tile0_h_m1 <= p;
        tcp_pkg::CMD_IN_TILE1_H:  o_in_tile1_h_m1 <= p;
        tcp_pkg::CMD_OUT_TILE_W:  o_out_tile_w_m1 <= p;
        tcp_pkg::CMD_OUT_TILE0_H: o_out_tile0_h_m1 <= p;
        tcp_pkg::CMD_OUT_TILE1_H: o_out_tile1_h_m1 <= p;
        tcp_pkg::CMD_OUT_W:       o_out_w_m1 <= p;
        tcp_pkg::CMD_OUT_H:       o_out_h_m1 <= p;
        tcp_pkg::CMD_OUT_D:       o_out_d_m1 <= p;
        tcp_pkg::CMD_KERNEL_W:    o_kernel_w_m1 <= p;
        tcp_pkg::CMD_KERNEL_H:    o_kernel_h_m1 <= p;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_out_signed       <= 1'b0;
      o_out_prec         <= 2'h0;
      o_out_layout       <= 2'h0;
      o_out_global_scale <= 1'b0;
      o_out_round        <= 2'h0;
      o_blk_w_m1         <= 5'h00;
      o_blk_h_m1         <= 5'h00;
      o_blk_d_m1         <= tcp_pkg::BLK_D_RST;
      out_zero_reg       <= 16'h0000;
      o_out_region       <= 3'h0;
    end else if (take && is_cmd0 && known) begin
      unique case (code)
        tcp_pkg::CMD_OUT_PREC: begin
          o_out_signed       <= p[tcp_pkg::OP_SIGN_POS];
          o_out_prec         <= p[tcp_pkg::OP_PREC_LSB +: 2];
          o_out_layout       <= p[tcp_pkg::OP_LAYOUT_LSB +: 2];
          o_out_global_scale <= p[tcp_pkg::OP_SCALE_POS];
          o_out_round        <= p[tcp_pkg::OP_ROUND_LSB +: 2];
        end
        tcp_pkg::CMD_BLK_W:      o_blk_w_m1 <= p[4:0];
        tcp_pkg::CMD_BLK_H:      o_blk_h_m1 <= p[4:0];
        tcp_pkg::CMD_BLK_D:      o_blk_d_m1 <= p[6:0];
        tcp_pkg::CMD_OUT_ZERO:   out_zero_reg <= p;
        tcp_pkg::CMD_OUT_REGION: o_out_region <= p[2:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Derived state
  // ****************************************************************
  // Extended offsets follow the stored signedness one cycle later, since the
  // producer may send the offset before or after the precision command
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_in_zero_ext       <= 17'h00000;
      o_out_zero_ext      <= 17'h00000;
      o_pad_after_upscale <= 1'b0;
    end else begin
      o_in_zero_ext  <= {o_in_signed & in_zero_reg[15], in_zero_reg};
      o_out_zero_ext <= {o_out_signed & out_zero_reg[15], out_zero_reg};
      o_pad_after_upscale <= (o_in_upscale != 2'h0);
    end
  end

  // ****************************************************************
  // Error flags and last command
  // ****************************************************************
  assign apb_wr = psel && penable && pready && pwrite;

  // A new error in the clearing cycle wins over the clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      err_reg <= 2'b00;
    end else begin
      err_reg[tcp_pkg::ERR_UNK_POS] <= (take && is_cmd0 && in_range && !known) ||
          (err_reg[tcp_pkg::ERR_UNK_POS] &&
           !(apb_wr && paddr == tcp_pkg::REG_ERR && pwdata[tcp_pkg::ERR_UNK_POS]));
      err_reg[tcp_pkg::ERR_RANGE_POS] <= (take && is_cmd0 &&
          ((known && bad_value) ||
           (code == tcp_pkg::CMD_KERNEL_WAIT && p > tcp_pkg::WAIT_N_MAX))) ||
          (err_reg[tcp_pkg::ERR_RANGE_POS] &&
           !(apb_wr && paddr == tcp_pkg::REG_ERR && pwdata[tcp_pkg::ERR_RANGE_POS]));
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      last_cmd_reg <= 10'h000;
    end else if (take && is_cmd0) begin
      last_cmd_reg <= code;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_en_reg <= tcp_pkg::CTRL_EN_RST;
    end else if (apb_wr && paddr == tcp_pkg::REG_CTRL) begin
      ctrl_en_reg <= pwdata[0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (paddr)
      tcp_pkg::REG_CTRL:     rd_mux[0] = ctrl_en_reg;
      tcp_pkg::REG_STATUS: begin
        rd_mux[3:0] = kcount_reg;
        rd_mux[tcp_pkg::ST_WAIT_POS]  = (state_reg == ST_WAIT);
        rd_mux[tcp_pkg::ST_PADUP_POS] = o_pad_after_upscale;
      end
      tcp_pkg::REG_ERR:      rd_mux[1:0] = err_reg;
      tcp_pkg::REG_LAST_CMD: rd_mux[9:0] = last_cmd_reg;
      default:               rd_ok = 1'b0;
    endcase
  end

  // Zero wait states: ready rises in the first access cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule : tcp_decoder
`default_nettype wire

// ==== tcp_sva.sv ====
// Port checker for the command parameter decoder
`timescale 1ns/1ps
`default_nettype none
module tcp_sva (
  input wire logic        i_clk_sys, i_rst, i_cmd_valid, o_cmd_ready,
  input wire logic        o_kernel_start, o_pad_after_upscale,
  input wire logic [15:0] i_cmd_word, i_cmd_param, o_in_depth_m1,
  input wire logic [6:0]  o_pad_top,
  input wire logic [1:0]  o_in_upscale,
  input wire logic [2:0]  o_in_region
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire logic tk = i_cmd_valid & o_cmd_ready;
  wire logic ks = i_cmd_word inside {16'h0002, 16'h0003, 16'h0005, 16'h0006};
  AST_KSTART: assert property (tk && ks |=> o_kernel_start)
    else $error("kernel start missing");
  AST_KONLY: assert property (o_kernel_start |-> $past(tk) && $past(ks))
    else $error("kernel start without cause");
  AST_WAIT: assert property (tk && i_cmd_word == 16'h0012 |=> !o_cmd_ready)
    else $error("ready kept after wait");
  AST_BADW: assert property (tk && i_cmd_word[15:10] != 0 |=> $stable(o_in_depth_m1))
    else $error("bad word changed state");
  AST_DEPTH: assert property (tk && i_cmd_word == 16'h0104 |=> o_in_depth_m1 == $past(i_cmd_param))
    else $error("depth not latched");
  AST_PAD: assert property (tk && i_cmd_word == 16'h0100 |=> o_pad_top == $past(i_cmd_param[6:0]))
    else $error("top pad not latched");
  AST_UPS: assert property (tk && i_cmd_word == 16'h0107 |=>
    o_in_upscale == $past(i_cmd_param[1:0]) ##1 o_pad_after_upscale == (o_in_upscale != 0))
    else $error("upscale mode wrong");
  AST_REGION: assert property (tk && i_cmd_word == 16'h010F |=> o_in_region == $past(i_cmd_param[2:0]))
    else $error("region not latched");
  AST_HOLD: assert property (!(tk && i_cmd_word == 16'h0104) |=> $stable(o_in_depth_m1))
    else $error("depth changed unasked");
endmodule // tcp_sva
`default_nettype wire

// ==== tcp_cmd_src.sv ====
// Command stream source standing in for the host-prepared stream
`timescale 1ns/1ps
`default_nettype none
module tcp_cmd_src (
  input  wire logic        i_clk_sys,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [15:0]      o_word,
  output logic [15:0]      o_param
);
  initial begin
    o_valid = 1'b0;
    o_word = 16'h0000;
    o_param = 16'h0000;
  end
  // Word held with its parameter until taken; one word per command
  task automatic send(input logic [15:0] w, input logic [15:0] p);
    o_valid <= 1'b1;
    o_word <= w;
    o_param <= p;
    do @(posedge i_clk_sys); while (i_ready !== 1'b1);
  endtask
  // Idle lines flip so a stale word never looks held
  task automatic idle;
    o_valid <= 1'b0;
    o_word <= ~o_word;
    o_param <= ~o_param;
    @(posedge i_clk_sys);
  endtask
endmodule // tcp_cmd_src
`default_nettype wire

// ==== tcp_decoder_tb.sv ====
// Self-checking bench for the command parameter decoder
`timescale 1ns/1ps
`default_nettype none
module tcp_decoder_tb;
  logic i_clk_sys, i_rst, i_cmd_valid, i_kernel_done, psel, penable, pwrite, pready, pslverr;
  logic o_cmd_ready, o_pad_after_upscale, o_in_signed, o_out_signed, o_out_global_scale;
  logic o_kernel_start, er;
  logic [15:0] i_cmd_word, i_cmd_param, o_in_depth_m1, o_in_tile_w_m1, o_in_tile0_h_m1;
  logic [15:0] o_in_tile1_h_m1, o_out_w_m1, o_out_h_m1, o_out_d_m1, o_out_tile_w_m1;
  logic [15:0] o_out_tile0_h_m1, o_out_tile1_h_m1, o_kernel_w_m1, o_kernel_h_m1;
  logic [1:0] o_in_prec, o_in_layout, o_in_ew_scale, o_in_round, o_in_upscale;
  logic [1:0] o_out_prec, o_out_layout, o_out_round;
  logic [6:0] o_pad_top, o_pad_left, o_blk_d_m1;
  logic [7:0] o_pad_right, o_pad_bottom;
  logic [16:0] o_in_zero_ext, o_out_zero_ext;
  logic [5:0] o_in_buf_end;
  logic [4:0] o_blk_w_m1, o_blk_h_m1;
  logic [2:0] o_in_region, o_out_region;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  int failures, samples_checked, p, m[290];
  tcp_decoder dut_u (.*);
  tcp_cmd_src src_u (.i_clk_sys, .i_ready(o_cmd_ready), .o_valid(i_cmd_valid),
    .o_word(i_cmd_word), .o_param(i_cmd_param));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input int e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmd(input int c, input int v, input bit u = 1'b1);
    if (u) m[c] = v;
    src_u.send(c[15:0], v[15:0]);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do @(posedge i_clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  // Model state compared after the offset extension has settled
  task automatic cmp;
    repeat (2) @(negedge i_clk_sys);
    chk({o_pad_top, o_pad_right}, (m[256] & 127) << 8 | m[258]);
    chk({o_pad_left, o_pad_bottom}, m[257] << 8 | m[259]);
    chk({o_in_tile0_h_m1, o_out_w_m1}, m[267] << 16 | m[273]);
    chk({o_out_h_m1, o_out_tile_w_m1}, m[274] << 16 | m[282]);
    chk({o_blk_h_m1, o_out_tile1_h_m1}, m[278] << 16 | m[284]);
    chk(o_in_depth_m1, m[260]);
    chk({o_in_round, 4'h0, o_in_ew_scale, o_in_layout, 2'h0, o_in_prec, 1'b0, o_in_signed},
      m[261]);
    chk({o_out_round, 5'h00, o_out_global_scale, o_out_layout, 3'h0, o_out_prec, o_out_signed},
      m[276]);
    chk({o_pad_after_upscale, o_in_upscale}, (m[263] != 0) << 2 | m[263]);
    chk(o_in_zero_ext, m[261][0] && m[265][15] ? m[265] | 32'h0001_0000 : m[265]);
    chk(o_out_zero_ext, m[276][0] && m[280][15] ? m[280] | 32'h0001_0000 : m[280]);
    chk({o_in_tile_w_m1, o_in_tile1_h_m1}, m[266] << 16 | m[268]);
    chk({o_out_tile0_h_m1, o_out_d_m1}, m[283] << 16 | m[275]);
    chk({o_in_buf_end, o_in_region, o_out_region}, m[269] << 6 | m[271] << 3 | m[287]);
    chk({o_blk_w_m1, o_blk_d_m1}, m[277] << 7 | m[279]);
    chk({o_kernel_w_m1, o_kernel_h_m1}, m[288] << 16 | m[289]);
    @(posedge i_clk_sys);
  endtask
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1_000_000;
    failures++;
    wrap_up;
  end
  initial begin
    {i_rst, i_kernel_done, psel, penable, pwrite, paddr, pwdata} = {2'h2, 3'h0, 44'h0};
    rnd = 32'h0000_EB2E;
    m[279] = 3;
    repeat (8) @(posedge i_clk_sys);
    cmp;
    i_rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      cmd(10'h105, k << 2 | (k & 1) << 6 | k << 8 | (k & 2) << 14 | k & 1);
      cmd(10'h114, k & 1 | k << 1 | (k & 1) << 6 | (k & 1) << 8 | k << 14);
      cmd(10'h107, k);
      src_u.idle;
      cmp;
    end
    for (int c = 10'h100; c <= 10'h121; c++) begin
      rnd = lf(rnd);
      case (c)
        10'h100, 10'h101: p = rnd % 128;
        10'h102, 10'h103: p = rnd % 129;
        10'h105: p = 4;
        10'h114: p = 3;
        10'h107: p = rnd % 3;
        10'h109, 10'h118: p = rnd[15:0] | 16'h8000;
        10'h10D: p = rnd % 25 * 2;
        10'h10F, 10'h11F: p = rnd % 8;
        10'h115, 10'h116: p = rnd % 32;
        10'h117: p = rnd % 125 + 3;
        default: p = rnd[15:0];
      endcase
      cmd(c, p, !(c inside {10'h106, 10'h108, 10'h10E, 10'h110, 10'h119, 10'h11D, 10'h11E}));
    end
    cmd(10'h100, 16'h0080);
    cmd(16'h0504, 16'h1234, 1'b0);
    src_u.idle;
    cmp;
    apb(1'b0, 12'h008, 32'h0);
    chk({er, rd[1:0]}, 3);
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 12'h008, 32'h0);
    chk({er, rd[1:0]}, 0);
    cmd(10'h002, 0);
    cmd(10'h006, 1);
    cmd(10'h012, 1);
    src_u.idle;
    repeat (3) @(posedge i_clk_sys);
    chk(o_cmd_ready, 0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[4:0], 5'h12);
    i_kernel_done <= 1'b1;
    @(posedge i_clk_sys);
    i_kernel_done <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk(o_cmd_ready, 1);
    cmd(10'h010, 0);
    cmd(10'h003, 0);
    cmd(10'h005, 0);
    cmd(10'h012, 3);
    cmd(10'h104, 16'hFFFF);
    src_u.idle;
    cmp;
    wrap_up;
  end
endmodule // tcp_decoder_tb
bind tcp_decoder tcp_sva chk_u (.*);
`default_nettype wire
